// ==== sac_regs.svh ====
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SAC_ADDR_CTRL 32'hE000EDD0
`define SAC_ADDR_COUNT 32'hE000EDD4
`define SAC_ADDR_SELECT 32'hE000EDD8
`define SAC_ADDR_BASE 32'hE000EDDC
`define SAC_ADDR_LIMIT 32'hE000EDE0
`define SAC_ADDR_FSTAT 32'hE000EDE4
`define SAC_ADDR_FADDR 32'hE000EDE8
// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define SAC_CTRL_EN 0
`define SAC_LIMIT_EN 0
`define SAC_LIMIT_NSC 1
`define SAC_GRAN_LSB 5
`define SAC_LIMIT_LOW 5'h1F
`define SAC_BASE_LOW 5'h00
`define SAC_SEL_W 8
`define SAC_FSTAT_DATA 0
`define SAC_FSTAT_ENTRY 1
`define SAC_HTRANS_ACT 1
`define SAC_HPROT_PRIV 1
`define SAC_EXEMPT_FIRST 32'hE0000000
`define SAC_EXEMPT_LAST 32'hE00FFFFF
`define SAC_WORD_ZERO 32'h0000_0000
`endif

// ==== sac_pkg.sv ====
`default_nettype none
package sac_pkg;
  // Encoded by strictness so that the stricter of NS, NSC and S is the larger one; exempt takes the top code
  typedef enum logic [1:0] {
    SAC_NS = 2'h0,
    SAC_NSC = 2'h1,
    SAC_S = 2'h2,
    SAC_EXEMPT = 2'h3
  } sac_attr_t;
endpackage : sac_pkg
`default_nettype wire

// ==== sac_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// One programmable region: write strobes in, stored fields and hits out
interface sac_region_if;
  logic wr_base;
  logic wr_limit;
  logic [31:0] wdata;
  logic [31:0] addr_d;
  logic [31:0] addr_f;
  logic [31:0] base_q;
  logic [31:0] limit_q;
  logic hit_d;
  logic hit_f;
  logic nsc_q;
  modport regn (input wr_base, wr_limit, wdata, addr_d, addr_f,
                output base_q, limit_q, hit_d, hit_f, nsc_q);
  modport ctl (output wr_base, wr_limit, wdata, addr_d, addr_f,
               input base_q, limit_q, hit_d, hit_f, nsc_q);
endinterface : sac_region_if

// One lookup: both unit results in, merged attribute and verdict out
interface sac_lookup_if;
  logic nonsecure;
  logic fetch;
  logic sg_first;
  logic exempt;
  sac_pkg::sac_attr_t prog_attr;
  sac_pkg::sac_attr_t ext_attr;
  sac_pkg::sac_attr_t attr;
  logic fault;
  logic secure_after;
  modport chk (input nonsecure, fetch, sg_first, exempt, prog_attr, ext_attr,
               output attr, fault, secure_after);
  modport req (output nonsecure, fetch, sg_first, exempt, prog_attr, ext_attr,
               input attr, fault, secure_after);
endinterface : sac_lookup_if
`default_nettype wire

// ==== sac_region.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_region (
  input wire logic hclk,
  input wire logic hresetn,
  sac_region_if.regn rif
);
  import sac_pkg::*;
  logic [31:`SAC_GRAN_LSB] base_r;
  logic [31:`SAC_GRAN_LSB] limit_r;
  logic en_r;
  logic nsc_r;

  // Bounds kept at 32-byte granule only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_r <= '0;
      limit_r <= '0;
      en_r <= 1'b0;
      nsc_r <= 1'b0;
    end else begin
      if (rif.wr_base) begin
        base_r <= rif.wdata[31:`SAC_GRAN_LSB];
      end
      if (rif.wr_limit) begin
        limit_r <= rif.wdata[31:`SAC_GRAN_LSB];
        en_r <= rif.wdata[`SAC_LIMIT_EN];
        nsc_r <= rif.wdata[`SAC_LIMIT_NSC];
      end
    end
  end

  // Inclusive match; low limit bits implied all ones
  assign rif.hit_d = en_r && (rif.addr_d[31:`SAC_GRAN_LSB] >= base_r) &&
                     (rif.addr_d[31:`SAC_GRAN_LSB] <= limit_r);
  assign rif.hit_f = en_r && (rif.addr_f[31:`SAC_GRAN_LSB] >= base_r) &&
                     (rif.addr_f[31:`SAC_GRAN_LSB] <= limit_r);
  assign rif.nsc_q = nsc_r;
  assign rif.base_q = {base_r, `SAC_BASE_LOW};
  assign rif.limit_q = {limit_r, 3'h0, nsc_r, en_r};
endmodule : sac_region
`default_nettype wire

// ==== sac_check.sv ====
`timescale 1ns/1ps
`default_nettype none
module sac_check (
  sac_lookup_if.chk lk
);
  import sac_pkg::*;

  // Merge both units, then judge the access
  always_comb begin
    if (lk.exempt || lk.ext_attr == SAC_EXEMPT) begin
      lk.attr = SAC_EXEMPT;
    end else if (lk.ext_attr > lk.prog_attr) begin
      lk.attr = lk.ext_attr;
    end else begin
      lk.attr = lk.prog_attr;
    end
    lk.fault = 1'b0;
    lk.secure_after = !lk.nonsecure;
    if (lk.fetch) begin
      case (lk.attr)
        SAC_NS: lk.secure_after = 1'b0;
        SAC_NSC: begin
          lk.fault = lk.nonsecure && !lk.sg_first;
          lk.secure_after = 1'b1;
        end
        SAC_S: begin
          lk.fault = lk.nonsecure;
          lk.secure_after = 1'b1;
        end
        default: lk.secure_after = !lk.nonsecure;
      endcase
    end else begin
      // NONSECURE_CALLABLE counts as Secure for data; NS and exempt open to all
      lk.fault = lk.nonsecure && (lk.attr == SAC_S || lk.attr == SAC_NSC);
    end
  end
endmodule : sac_check
`default_nettype wire

// ==== sac_top.sv ====
// Functional notes
// - Non-secure memory is reachable from both security states.
// - Executing state follows attribute of fetched memory: Secure or Non-secure.
// - Non-secure data access to Secure address is blocked and faults.
// - Only callable addresses may be entered from Non-secure state.
// - Non-secure branch to Secure faults unless callable and gateway first.
// - Non-secure data access to callable memory refused; gateway branch allowed.
// - Exempt addresses are accessible from both states without fault.
// - With both units present, the stricter attribute wins, except that an exempt answer always wins.
// - Only Secure privileged bus writes change the configuration.
// - Region count is a parameter, reported by the count register.
// - Region base and limit are held at 32-byte granularity.
// - Select register chooses which region base and limit registers reach.
// - Low five limit bits are treated as all ones.
// - Per-region callable bit picks Non-secure or callable attribute.
// - Per-region enable bit gates that region in lookup.
// - Regions apply only after the global enable bit is set.
// - Internal exempt addresses stay exempt whatever regions say.
// - Separate Secure and Non-secure protection banks apply after attribution.
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_top #(
  parameter int NUM_REGIONS = 8,
  parameter bit EXT_PRESENT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic hnonsec,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic d_valid,
  input wire logic [31:0] d_addr,
  input wire logic d_nonsecure,
  input wire sac_pkg::sac_attr_t ext_d_attr,
  output logic d_rsp_valid,
  output sac_pkg::sac_attr_t d_attr,
  output logic d_fault,
  output logic d_mpu_go,
  output logic d_mpu_secure,
  input wire logic f_valid,
  input wire logic [31:0] f_addr,
  input wire logic f_sg_first,
  input wire sac_pkg::sac_attr_t ext_f_attr,
  output logic f_rsp_valid,
  output sac_pkg::sac_attr_t f_attr,
  output logic f_fault,
  output logic exec_secure,
  output logic security_fault
);
  import sac_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic acc_take;
  logic wr_pend_r;
  logic rd_wait_r;
  logic acc_ok_r;
  logic [31:0] addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic wr_go;
  logic sel_ok;
  logic en_r;
  logic [`SAC_SEL_W-1:0] sel_r;
  logic [1:0] fstat_r;
  logic [31:0] faddr_r;
  logic exec_secure_r;
  logic d_rsp_valid_r;
  logic d_fault_r;
  logic d_mpu_go_r;
  logic d_mpu_secure_r;
  sac_attr_t d_attr_r;
  logic f_rsp_valid_r;
  logic f_fault_r;
  sac_attr_t f_attr_r;
  logic security_fault_r;
  logic d_evt;
  logic f_evt;
  logic [NUM_REGIONS-1:0] hit_d_v;
  logic [NUM_REGIONS-1:0] hit_f_v;
  logic [NUM_REGIONS-1:0] nsc_v;
  logic [31:0] base_v [NUM_REGIONS];
  logic [31:0] limit_v [NUM_REGIONS];

  sac_lookup_if lk_d ();
  sac_lookup_if lk_f ();

  // ----------------------------------------------------------------------
  // Region store, one instance per programmable region
  // ----------------------------------------------------------------------
  // Out-of-range selections touch no region
  assign sel_ok = (sel_r < `SAC_SEL_W'(NUM_REGIONS));

  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_rgn
    sac_region_if rif ();
    // Strobe only the selected region
    assign rif.wr_base = wr_go && sel_ok && addr_r == `SAC_ADDR_BASE &&
                         sel_r == `SAC_SEL_W'(g);
    assign rif.wr_limit = wr_go && sel_ok && addr_r == `SAC_ADDR_LIMIT &&
                          sel_r == `SAC_SEL_W'(g);
    assign rif.wdata = hwdata;
    assign rif.addr_d = d_addr;
    assign rif.addr_f = f_addr;
    assign hit_d_v[g] = rif.hit_d;
    assign hit_f_v[g] = rif.hit_f;
    assign nsc_v[g] = rif.nsc_q;
    assign base_v[g] = rif.base_q;
    assign limit_v[g] = rif.limit_q;
    sac_region u_rgn (
      .hclk(hclk),
      .hresetn(hresetn),
      .rif(rif)
    );
  end

  // ----------------------------------------------------------------------
  // Programmable attribution
  // ----------------------------------------------------------------------
  // Zero or several hits resolve Secure; overlap can never open memory
  function automatic sac_attr_t prog_lookup(input logic enable,
                                            input logic [NUM_REGIONS-1:0] hits,
                                            input logic [NUM_REGIONS-1:0] nscs);
    sac_attr_t res;
    res = SAC_S;
    if (enable && hits != '0 && (hits & (hits - 1'b1)) == '0) begin
      res = ((hits & nscs) != '0) ? SAC_NSC : SAC_NS;
    end
    return res;
  endfunction : prog_lookup

  // Fixed internal exempt window, not affected by any region
  function automatic logic in_exempt(input logic [31:0] a);
    return (a >= `SAC_EXEMPT_FIRST) && (a <= `SAC_EXEMPT_LAST);
  endfunction : in_exempt

  // ----------------------------------------------------------------------
  // Lookup requests into the merge and check stage
  // ----------------------------------------------------------------------
  // Absent external unit answers least strict so it never dominates
  assign lk_d.nonsecure = d_nonsecure;
  assign lk_d.fetch = 1'b0;
  assign lk_d.sg_first = 1'b0;
  assign lk_d.exempt = in_exempt(d_addr);
  assign lk_d.prog_attr = prog_lookup(en_r, hit_d_v, nsc_v);
  assign lk_d.ext_attr = EXT_PRESENT ? ext_d_attr : SAC_NS;

  assign lk_f.nonsecure = !exec_secure_r;
  assign lk_f.fetch = 1'b1;
  assign lk_f.sg_first = f_sg_first;
  assign lk_f.exempt = in_exempt(f_addr);
  assign lk_f.prog_attr = prog_lookup(en_r, hit_f_v, nsc_v);
  assign lk_f.ext_attr = EXT_PRESENT ? ext_f_attr : SAC_NS;

  sac_check u_chk_d (
    .lk(lk_d)
  );

  sac_check u_chk_f (
    .lk(lk_f)
  );

  assign d_evt = d_valid && lk_d.fault;
  assign f_evt = f_valid && lk_f.fault;

  // ----------------------------------------------------------------------
  // Data lookup answer, one cycle after the request
  // ----------------------------------------------------------------------
  // Protection bank follows requester state, only for passed accesses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_rsp_valid_r <= 1'b0;
      d_attr_r <= SAC_S;
      d_fault_r <= 1'b0;
      d_mpu_go_r <= 1'b0;
      d_mpu_secure_r <= 1'b0;
    end else begin
      d_rsp_valid_r <= d_valid;
      if (d_valid) begin
        d_attr_r <= lk_d.attr;
        d_fault_r <= lk_d.fault;
        d_mpu_secure_r <= !d_nonsecure;
      end
      d_mpu_go_r <= d_valid && !lk_d.fault;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch lookup answer and executing security state
  // ----------------------------------------------------------------------
  // A faulting fetch leaves the state alone so no entry is half taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_rsp_valid_r <= 1'b0;
      f_attr_r <= SAC_S;
      f_fault_r <= 1'b0;
      exec_secure_r <= 1'b1;
    end else begin
      f_rsp_valid_r <= f_valid;
      if (f_valid) begin
        f_attr_r <= lk_f.attr;
        f_fault_r <= lk_f.fault;
        if (!lk_f.fault) begin
          exec_secure_r <= lk_f.secure_after;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Security fault pulse, sticky status and faulting address
  // ----------------------------------------------------------------------
  // Hardware set beats a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      security_fault_r <= 1'b0;
      fstat_r <= 2'h0;
      faddr_r <= `SAC_WORD_ZERO;
    end else begin
      security_fault_r <= d_evt || f_evt;
      if (wr_go && addr_r == `SAC_ADDR_FSTAT) begin
        fstat_r <= fstat_r & ~hwdata[1:0];
      end
      if (d_evt) begin
        fstat_r[`SAC_FSTAT_DATA] <= 1'b1;
      end
      if (f_evt) begin
        fstat_r[`SAC_FSTAT_ENTRY] <= 1'b1;
      end
      // Data fault address kept when both fault together
      if (d_evt) begin
        faddr_r <= d_addr;
      end else if (f_evt) begin
        faddr_r <= f_addr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave: address phase capture
  // ----------------------------------------------------------------------
  // Reads wait one cycle so they always see the previous write
  assign acc_take = hsel && hready && htrans[`SAC_HTRANS_ACT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      acc_ok_r <= 1'b0;
      addr_r <= `SAC_WORD_ZERO;
    end else begin
      if (hready) begin
        wr_pend_r <= acc_take && hwrite;
        acc_ok_r <= hprot[`SAC_HPROT_PRIV] && !hnonsec;
        if (acc_take) begin
          addr_r <= haddr;
        end
      end
      rd_wait_r <= acc_take && !hwrite;
    end
  end

  // Only Secure privileged writes land
  assign wr_go = wr_pend_r && acc_ok_r && hready;

  // ----------------------------------------------------------------------
  // Control and select registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      sel_r <= '0;
    end else begin
      if (wr_go && addr_r == `SAC_ADDR_CTRL) begin
        en_r <= hwdata[`SAC_CTRL_EN];
      end
      if (wr_go && addr_r == `SAC_ADDR_SELECT) begin
        sel_r <= hwdata[`SAC_SEL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Non-secure or unprivileged reads see zero; config is not disclosed
  always_comb begin
    rd_mux = `SAC_WORD_ZERO;
    if (acc_ok_r) begin
      case (addr_r)
        `SAC_ADDR_CTRL: rd_mux[`SAC_CTRL_EN] = en_r;
        `SAC_ADDR_COUNT: rd_mux[`SAC_SEL_W-1:0] = `SAC_SEL_W'(NUM_REGIONS);
        `SAC_ADDR_SELECT: rd_mux[`SAC_SEL_W-1:0] = sel_r;
        `SAC_ADDR_FSTAT: rd_mux[1:0] = fstat_r;
        `SAC_ADDR_FADDR: rd_mux = faddr_r;
        default: rd_mux = `SAC_WORD_ZERO;
      endcase
      for (int i = 0; i < NUM_REGIONS; i++) begin
        if (sel_r == `SAC_SEL_W'(i)) begin
          if (addr_r == `SAC_ADDR_BASE) begin
            rd_mux = base_v[i];
          end
          if (addr_r == `SAC_ADDR_LIMIT) begin
            rd_mux = limit_v[i];
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= `SAC_WORD_ZERO;
    end else if (rd_wait_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout = !rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign d_rsp_valid = d_rsp_valid_r;
  assign d_attr = d_attr_r;
  assign d_fault = d_fault_r;
  assign d_mpu_go = d_mpu_go_r;
  assign d_mpu_secure = d_mpu_secure_r;
  assign f_rsp_valid = f_rsp_valid_r;
  assign f_attr = f_attr_r;
  assign f_fault = f_fault_r;
  assign exec_secure = exec_secure_r;
  assign security_fault = security_fault_r;

  // Unused transfer size: only whole words are supported
  logic unused_size;
  assign unused_size = ^hsize;
endmodule : sac_top
`default_nettype wire

// ==== sac_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic d_valid,
  input wire logic [31:0] d_addr,
  input wire logic d_nonsecure,
  input wire sac_pkg::sac_attr_t ext_d_attr,
  input wire logic d_rsp_valid,
  input wire sac_pkg::sac_attr_t d_attr,
  input wire logic d_fault,
  input wire logic d_mpu_go,
  input wire logic d_mpu_secure,
  input wire logic f_valid,
  input wire logic f_sg_first,
  input wire logic f_rsp_valid,
  input wire sac_pkg::sac_attr_t f_attr,
  input wire logic f_fault,
  input wire logic exec_secure,
  input wire logic security_fault
);
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // Lookup properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic in_win;
  // Internal exempt window, fixed whatever the regions hold
  assign in_win = (d_addr >= `SAC_EXEMPT_FIRST) && (d_addr <= `SAC_EXEMPT_LAST);
  // Data request and its answer one cycle on
  sequence s_data_req;
    d_valid ##1 d_rsp_valid;
  endsequence
  // Two idle cycles first, so the executing state has settled
  sequence s_ns_fetch;
    (!f_valid) [*2] ##1 (f_valid && !exec_secure) ##1 f_rsp_valid;
  endsequence
  a_ext_exempt: assert property (d_valid && ext_d_attr == SAC_EXEMPT |=> d_attr == SAC_EXEMPT && !d_fault)
    else $error("exempt answer not passed through");
  a_internal_exempt: assert property (d_valid && in_win |=> d_attr == SAC_EXEMPT)
    else $error("internal window lost its exempt class");
  a_ext_strict: assert property (d_valid && ext_d_attr == SAC_S && !in_win |=> d_attr == SAC_S)
    else $error("stricter external answer lost");
  a_data_fault: assert property (
    s_data_req |-> d_fault == ($past(d_nonsecure) && d_attr inside {SAC_S, SAC_NSC}))
    else $error("data fault does not match class and requester");
  a_ns_reachable: assert property (d_rsp_valid && d_attr == SAC_NS |-> !d_fault)
    else $error("Non-secure memory refused");
  a_bank_select: assert property (
    s_data_req |-> d_mpu_go == !d_fault && d_mpu_secure == !$past(d_nonsecure))
    else $error("protection bank hand-off wrong");
  a_fault_flag: assert property ((d_rsp_valid && d_fault) || (f_rsp_valid && f_fault) |-> security_fault)
    else $error("fault not flagged");
  a_entry_gate: assert property (
    s_ns_fetch |-> f_fault || f_attr inside {SAC_NS, SAC_EXEMPT} || (f_attr == SAC_NSC && $past(f_sg_first)))
    else $error("illegal entry into Secure code allowed");
  a_gateway_pass: assert property (
    s_ns_fetch ##0 (f_attr == SAC_NSC && $past(f_sg_first)) |-> !f_fault)
    else $error("gateway entry refused");
  a_state_ns: assert property (f_rsp_valid && !f_fault && f_attr == SAC_NS |-> ##[0:1] !exec_secure)
    else $error("state not Non-secure after Non-secure fetch");
endmodule : sac_chk
bind sac_top sac_chk u_chk (
  .hclk, .hresetn, .d_valid, .d_addr, .d_nonsecure, .ext_d_attr, .d_rsp_valid, .d_attr, .d_fault,
  .d_mpu_go, .d_mpu_secure, .f_valid, .f_sg_first, .f_rsp_valid, .f_attr, .f_fault, .exec_secure,
  .security_fault
);
`default_nettype wire

// ==== sac_ext_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sac_ext_model (
  input wire logic [31:0] d_addr,
  input wire logic [31:0] f_addr,
  output var sac_pkg::sac_attr_t ext_d_attr,
  output var sac_pkg::sac_attr_t ext_f_attr
);
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // Fixed map
  // ----------------------------------------------------------------
  // Low 64 MB in 16 MB slices: NS, NONSECURE_CALLABLE, S, exempt; the rest NS so the
  // programmable unit alone decides there
  function automatic sac_attr_t sac_map(input logic [31:0] a);
    return (a[31:26] == 6'h00) ? sac_attr_t'(a[25:24]) : SAC_NS;
  endfunction : sac_map
  // Same-cycle answer on both paths
  assign ext_d_attr = sac_map(d_addr);
  assign ext_f_attr = sac_map(f_addr);
endmodule : sac_ext_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module tb_top;
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and rows
  // ----------------------------------------------------------------
  // Flags: fetch, nonsecure, gateway first, fault, secure after
  typedef struct {
    logic [4:0] fl;
    logic [31:0] a;
    sac_attr_t at;
  } sac_row_t;
  localparam int NREG = 7;
  logic hclk, hready, hreadyout, hresp, d_rsp_valid, d_fault, d_mpu_go, d_mpu_secure;
  logic f_rsp_valid, f_fault, exec_secure, security_fault;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hnonsec = 1'b0;
  logic d_valid = 1'b0, d_nonsecure = 1'b0, f_valid = 1'b0, f_sg_first = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hprot = 4'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d_addr = 32'h0, f_addr = 32'h0, hrdata, rd;
  sac_attr_t ext_d_attr, ext_f_attr, d_attr, f_attr;
  int fails = 0, n_tests = 0;
  // Region base and limit words; region 3 left disabled
  logic [63:0] rg [NREG] = '{64'h00001000_00001FE1, 64'h00002000_00002003, 64'h00001800_00001801,
    64'h00003000_00003000, 64'h02000000_02000001, 64'h01000000_01000003, 64'hE0000000_E0000001};
  sac_row_t rows [18] = '{
    '{5'b01001, 32'h0000_1000, SAC_NS}, '{5'b00001, 32'h0000_1004, SAC_NS},
    '{5'b01011, 32'h0000_1810, SAC_S}, '{5'b01001, 32'h0000_1FFC, SAC_NS},
    '{5'b01011, 32'h0000_2000, SAC_NSC}, '{5'b01011, 32'h0000_3000, SAC_S},
    '{5'b01011, 32'h0200_0010, SAC_S}, '{5'b01001, 32'h0300_0000, SAC_EXEMPT},
    '{5'b01001, 32'hE000_0010, SAC_EXEMPT}, '{5'b00001, 32'h0000_0FFC, SAC_S},
    '{5'b10000, 32'h0000_1000, SAC_NS}, '{5'b10101, 32'h0100_0000, SAC_NSC},
    '{5'b10000, 32'h0000_1000, SAC_NS}, '{5'b10010, 32'h0000_2000, SAC_NSC},
    '{5'b10110, 32'h0000_3000, SAC_S}, '{5'b10000, 32'h0300_0000, SAC_EXEMPT},
    '{5'b10101, 32'h0000_2010, SAC_NSC}, '{5'b10001, 32'h0000_3000, SAC_S}};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  sac_top #(.NUM_REGIONS(NREG), .EXT_PRESENT(1'b1)) u_sac_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hprot, .hnonsec, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .d_valid, .d_addr, .d_nonsecure, .ext_d_attr, .d_rsp_valid, .d_attr,
    .d_fault, .d_mpu_go, .d_mpu_secure, .f_valid, .f_addr, .f_sg_first, .ext_f_attr, .f_rsp_valid,
    .f_attr, .f_fault, .exec_secure, .security_fault
  );
  sac_ext_model u_sac_ext_model (.d_addr, .f_addr, .ext_d_attr, .ext_f_attr);
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Look at ready mid-cycle, where it is settled, then pass the edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end else begin
      rd = hrdata;
      @(posedge hclk);
    end
  endtask : wait_rdy
  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask : bus
  // Answer one cycle on, executing state checked one cycle later
  task automatic look(input sac_row_t r);
    f_valid <= r.fl[4];
    d_valid <= !r.fl[4];
    f_addr <= r.a;
    d_addr <= r.a;
    d_nonsecure <= r.fl[3];
    f_sg_first <= r.fl[2];
    @(posedge hclk);
    f_valid <= 1'b0;
    d_valid <= 1'b0;
    @(negedge hclk);
    if (r.fl[4]) begin
      check(32'({f_rsp_valid, f_fault, f_attr}), 32'({1'b1, r.fl[1], r.at}));
    end else begin
      check(32'({d_rsp_valid, d_fault, d_attr, d_mpu_go, d_mpu_secure}),
            32'({1'b1, r.fl[1], r.at, !r.fl[1], !r.fl[3]}));
    end
    check(32'(security_fault), 32'(r.fl[1]));
    @(posedge hclk);
    @(negedge hclk);
    check(32'(exec_secure), 32'(r.fl[0]));
    @(posedge hclk);
  endtask : look
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    check(32'(exec_secure), 32'h1);
    bus(1'b0, `SAC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `SAC_ADDR_COUNT, 32'h0);
    check(rd, 32'(NREG));
    look('{5'b01011, 32'h0000_1000, SAC_S});
    $display("test reset done");
    // Regions first, global enable last
    for (int i = 0; i < NREG; i++) begin
      bus(1'b1, `SAC_ADDR_SELECT, 32'(i));
      bus(1'b1, `SAC_ADDR_BASE, rg[i][63:32]);
      bus(1'b1, `SAC_ADDR_LIMIT, rg[i][31:0]);
    end
    bus(1'b1, `SAC_ADDR_CTRL, 32'h1);
    foreach (rows[i]) begin
      look(rows[i]);
    end
    $display("test lookup rows done");
    bus(1'b1, `SAC_ADDR_SELECT, 32'h1);
    bus(1'b0, `SAC_ADDR_LIMIT, 32'h0);
    check(rd, 32'h0000_2003);
    bus(1'b1, `SAC_ADDR_SELECT, 32'h0);
    bus(1'b1, `SAC_ADDR_BASE, 32'h0000_101F);
    bus(1'b0, `SAC_ADDR_BASE, 32'h0);
    check(rd, 32'h0000_1000);
    bus(1'b1, `SAC_ADDR_LIMIT, 32'h0000_1FFD);
    bus(1'b0, `SAC_ADDR_LIMIT, 32'h0);
    check(rd, 32'h0000_1FE1);
    // Select past the last region reaches nothing
    bus(1'b1, `SAC_ADDR_SELECT, 32'(NREG));
    bus(1'b1, `SAC_ADDR_BASE, 32'h0000_4000);
    bus(1'b0, `SAC_ADDR_BASE, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 32'hE000_EDF0, 32'h0);
    check(rd, 32'h0);
    $display("test register access done");
    // Non-secure, then unprivileged, try to switch the unit off
    for (int i = 0; i < 2; i++) begin
      hnonsec <= (i == 0);
      hprot <= (i == 0) ? 4'h2 : 4'h0;
      bus(1'b1, `SAC_ADDR_CTRL, 32'h0);
      hnonsec <= 1'b0;
      hprot <= 4'h2;
      bus(1'b0, `SAC_ADDR_CTRL, 32'h0);
      check(rd, 32'h1);
    end
    bus(1'b1, `SAC_ADDR_CTRL, 32'h0);
    look('{5'b01011, 32'h0000_1000, SAC_S});
    // Sticky status and last faulting address, then write-one clear
    bus(1'b0, `SAC_ADDR_FADDR, 32'h0);
    check(rd, 32'h0000_1000);
    bus(1'b0, `SAC_ADDR_FSTAT, 32'h0);
    check(rd, 32'h3);
    bus(1'b1, `SAC_ADDR_FSTAT, 32'h3);
    bus(1'b0, `SAC_ADDR_FSTAT, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    $display("test refused writes and disable done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
